// *** verilog/sms_spi.sv ***
// SPI master/slave unit with double-buffered transmit and Wishbone registers
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
module sms_spi
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic warm_reset,
	input wire logic serial_irq_enable,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [sms_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic spi_irq,
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic miso_i,
	input wire logic ss_n_i,
	output sms_pkg::sms_pins_t pins_o
);
	sms_pkg::sms_ctrl_t ctl_q;
	sms_pkg::sms_ctrl_t ctl_d;
	sms_pkg::sms_pins_t pins_d;
	logic [7:0] sh_q;
	logic [7:0] sh_d;
	logic [7:0] rx_q;
	logic [7:0] txbuf_q;
	logic [2:0] bit_q;
	logic [3:0] edge_q;
	logic busy_q;
	logic busy_d;
	logic done_q;
	logic arm_q;
	logic write_collision_flag_q;
	logic full_q;
	logic slave_out_disable_q;
	logic enh_q;
	logic sck_prev_q;
	logic ack_q;
	logic [7:0] dat_q;
	logic irq_q;

	// Bus decode
	logic req;
	logic wr;
	logic rd;
	logic hit_data;
	logic hit_stat;
	logic hit_ctrl;
	logic data_wr;
	logic data_acc;
	logic stat_rd;
	logic clear_ev;
	logic [7:0] stat_val;
	logic [7:0] rd_mux;

	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign rd = req && !wb_we_i;
	assign hit_data = (wb_adr_i[sms_pkg::ADR_W-1:2] == sms_pkg::IDX_DATA);
	assign hit_stat = (wb_adr_i[sms_pkg::ADR_W-1:2] == sms_pkg::IDX_STAT);
	assign hit_ctrl = (wb_adr_i[sms_pkg::ADR_W-1:2] == sms_pkg::IDX_CTRL);
	assign data_wr = wr && hit_data;
	assign data_acc = req && hit_data && (wr || rd);
	assign stat_rd = rd && hit_stat;
	assign clear_ev = arm_q && data_acc;

	// Mode and link events
	logic master_mode;
	logic slave_sel;
	logic tick;
	logic lead;
	logic trail;
	logic samp_ev;
	logic drive_ev;
	logic in_bit;
	logic out_bit;
	logic sck_rise;
	logic sck_fall;
	logic lead_s;
	logic trail_s;
	logic end_m;
	logic end_s;
	logic xfer_end;
	logic start_m;
	logic load_window;
	logic out_upd;
	logic [7:0] shifted;

	assign master_mode = ctl_q.spi_on && ctl_q.master;
	assign slave_sel = ctl_q.spi_on && !ctl_q.master && !ss_n_i;
	assign sck_rise = sck_i && !sck_prev_q;
	assign sck_fall = !sck_i && sck_prev_q;
	assign lead_s = slave_sel && (ctl_q.clock_polarity ? sck_fall : sck_rise);
	assign trail_s = slave_sel && busy_q && (ctl_q.clock_polarity ? sck_rise : sck_fall);
	assign lead = master_mode ? (tick && busy_q && !edge_q[0]) : lead_s;
	assign trail = master_mode ? (tick && busy_q && edge_q[0]) : trail_s;
	assign samp_ev = ctl_q.clock_phase ? trail : lead;
	assign drive_ev = ctl_q.clock_phase ? lead : trail;
	assign in_bit = master_mode ? miso_i : mosi_i;
	assign out_bit = ctl_q.bit_order ? sh_q[0] : sh_q[7];
	assign shifted = ctl_q.bit_order ? {in_bit, sh_q[7:1]} : {sh_q[6:0], in_bit};
	assign end_m = master_mode && trail && (edge_q == sms_pkg::LAST_EDGE);
	assign end_s = !master_mode && samp_ev && (bit_q == sms_pkg::LAST_BIT);
	assign xfer_end = end_m || end_s;
	assign start_m = master_mode && !busy_q && data_wr;
	assign load_window = !busy_q || (bit_q < sms_pkg::LOAD_WIN_END);
	assign out_upd = drive_ev || !busy_q || (master_mode && edge_q == 4'h0 && !tick);

	assign stat_val = {done_q, (enh_q ? full_q : write_collision_flag_q), load_window, 3'h0, slave_out_disable_q, enh_q};
	assign rd_mux = hit_data ? rx_q : hit_stat ? stat_val : hit_ctrl ? ctl_q : 8'h00;

	sms_clkdiv u_div
	(
		.core_clk(core_clk),
		.resetn(resetn),
		.run(master_mode && busy_q),
		.rate(ctl_q.rate),
		.tick(tick)
	);

	// Shift register: idle write, buffer unload, or sampling
	always_comb
	begin
		sh_d = sh_q;
		if (samp_ev)
			sh_d = shifted;
		if (!busy_q && data_wr)
			sh_d = wb_dat_i[7:0];
		if (xfer_end && enh_q && full_q)
			sh_d = txbuf_q;
	end

	always_comb
	begin
		busy_d = busy_q;
		if (start_m || (lead_s && !busy_q))
			busy_d = 1'b1;
		if (xfer_end)
			busy_d = end_m && enh_q && full_q;
		if (!ctl_q.spi_on || (!master_mode && ss_n_i))
			busy_d = 1'b0;
	end

	always_comb
	begin
		ctl_d = ctl_q;
		if (wr && hit_ctrl)
			ctl_d = wb_dat_i[7:0];
	end

	always_comb
	begin
		pins_d.sck = (master_mode && busy_q && tick) ? !pins_o.sck : (busy_q ? pins_o.sck : ctl_q.clock_polarity);
		pins_d.sck_oe = master_mode;
		pins_d.mosi = out_upd ? out_bit : pins_o.mosi;
		pins_d.mosi_oe = master_mode;
		pins_d.miso = out_upd ? out_bit : pins_o.miso;
		pins_d.miso_oe = slave_sel && !slave_out_disable_q;
	end

	// Data path: cleared only by cold reset
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sh_q <= sms_pkg::DATA_RST;
			rx_q <= sms_pkg::DATA_RST;
			txbuf_q <= sms_pkg::DATA_RST;
		end
		else
		begin
			sh_q <= sh_d;
			if (xfer_end)
				rx_q <= samp_ev ? shifted : sh_q;
			if (data_wr && busy_q && enh_q)
				txbuf_q <= wb_dat_i[7:0];
		end
	end

	// Control, flags and sequencing
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctl_q <= sms_pkg::CTRL_RST;
			slave_out_disable_q <= sms_pkg::ST_SLAVE_OUT_DISABLE_RST;
			enh_q <= sms_pkg::ST_ENH_RST;
			busy_q <= 1'b0;
			bit_q <= 3'h0;
			edge_q <= 4'h0;
			done_q <= 1'b0;
			arm_q <= 1'b0;
			write_collision_flag_q <= 1'b0;
			full_q <= 1'b0;
			sck_prev_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else if (warm_reset)
		begin
			ctl_q <= sms_pkg::CTRL_RST;
			slave_out_disable_q <= sms_pkg::ST_SLAVE_OUT_DISABLE_RST;
			enh_q <= sms_pkg::ST_ENH_RST;
			busy_q <= 1'b0;
			bit_q <= 3'h0;
			edge_q <= 4'h0;
			done_q <= 1'b0;
			arm_q <= 1'b0;
			write_collision_flag_q <= 1'b0;
			full_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			ctl_q <= ctl_d;
			if (wr && hit_stat)
			begin
				slave_out_disable_q <= wb_dat_i[sms_pkg::ST_SLAVE_OUT_DISABLE];
				enh_q <= wb_dat_i[sms_pkg::ST_ENH];
			end
			busy_q <= busy_d;
			sck_prev_q <= sck_i;
			if (!busy_d || xfer_end)
			begin
				bit_q <= 3'h0;
				edge_q <= 4'h0;
			end
			else
			begin
				if (samp_ev)
					bit_q <= bit_q + 3'h1;
				if (master_mode && tick)
					edge_q <= edge_q + 4'h1;
			end
			done_q <= xfer_end || (done_q && !clear_ev);
			arm_q <= (stat_rd && done_q) || (arm_q && !data_acc);
			write_collision_flag_q <= (data_wr && busy_q && !enh_q) || (write_collision_flag_q && !(clear_ev && !enh_q));
			full_q <= (data_wr && busy_q && enh_q) || (full_q && !xfer_end);
			irq_q <= done_q && ctl_q.irq_en && serial_irq_enable;
		end
	end

	// Bus answer and pins
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ack_q <= 1'b0;
			dat_q <= 8'h00;
			pins_o <= '0;
		end
		else
		begin
			ack_q <= req;
			if (rd)
				dat_q <= rd_mux;
			pins_o <= pins_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = {24'h000000, dat_q};
	assign spi_irq = irq_q;

	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn || warm_reset);

	property p_irq_gate;
		(done_q && ctl_q.irq_en && serial_irq_enable) |=> spi_irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq not raised");

	property p_done_set;
		xfer_end |=> done_q;
	endproperty
	a_done_set: assert property (p_done_set) else $error("done not set");

	property p_done_clear;
		$fell(done_q) |-> $past(arm_q) && $past(data_acc);
	endproperty
	a_done_clear: assert property (p_done_clear) else $error("done cleared wrongly");

	property p_write_collision_flag;
		(data_wr && busy_q && !enh_q) |=> write_collision_flag_q && (txbuf_q == $past(txbuf_q));
	endproperty
	a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision missed");

	property p_write_collision_flag_clr;
		(clear_ev && !enh_q && !(data_wr && busy_q) && !xfer_end) |=> !write_collision_flag_q && !done_q;
	endproperty
	a_write_collision_flag_clr: assert property (p_write_collision_flag_clr) else $error("collision not cleared");

	property p_full;
		(data_wr && busy_q && enh_q) |=> full_q && stat_val[sms_pkg::ST_WRITE_COLLISION_FLAG] && txbuf_q == $past(wb_dat_i[7:0]);
	endproperty
	a_full: assert property (p_full) else $error("buffer not loaded");

	property p_restart;
		(end_m && enh_q && full_q && !data_wr) |=> busy_q && !full_q && sh_q == $past(txbuf_q);
	endproperty
	a_restart: assert property (p_restart) else $error("no restart");

	property p_ldwin;
		busy_q && bit_q >= 3'h4 |-> !stat_val[sms_pkg::ST_LDWIN];
	endproperty
	a_ldwin: assert property (p_ldwin) else $error("load window high late");

	property p_tri;
		slave_out_disable_q |=> !pins_o.miso_oe;
	endproperty
	a_tri: assert property (p_tri) else $error("miso driven");

	property p_rate0;
		(tick && busy_q && ctl_q.rate == 2'h0 && edge_q != sms_pkg::LAST_EDGE) |=> !tick ##1 tick;
	endproperty
	a_rate0: assert property (p_rate0) else $error("f/4 spacing wrong");

	property p_idle_sck;
		(master_mode && !busy_q && !$past(busy_q)) |=> pins_o.sck == $past(ctl_q.clock_polarity);
	endproperty
	a_idle_sck: assert property (p_idle_sck) else $error("sck idle level");

	c_master: cover property (end_m);
	c_slave: cover property (end_s);
	c_restart: cover property (end_m && enh_q && full_q);
endmodule // sms_spi

// *** common/sms_pkg.sv ***
// Package of constants and carrier types for the SPI master/slave unit
//
// Function
// - Byte end sets done flag; interrupt only when both enables set.
// - Done flag clears after status read then data register access.
// - Normal mode: data write during transfer sets collision, data unchanged.
// - Normal mode: data read during transfer is not trustworthy.
// - Normal mode: collision flag clears together with done flag.
// - Enhanced mode: collision flag means buffer full; writes overwrite buffer.
// - Enhanced mode: buffer full clears when byte moves to shifter.
// - Load window high during bits 0-3, low during bits 4-7.
// - Slave output disable tri-states the slave data output.
// - Enhanced select: 0 single buffered, 1 double buffered via data address.
// - Master: rate bits pick SCK; slave follows incoming clock.
// - Phase and polarity pick one of four clock/data relations.
// - Data register survives warm reset.
// - Rate codes 00..11 divide clock by 4, 8, 32, 64.
// - Bit order 1 sends LSB first, 0 sends MSB first.
// - Master select 1 is master; polarity 1 idles clock high.
// - Slave retransmits last received byte when nothing new loaded.
package sms_pkg;
	localparam int ADR_W = 10;
	// Register word indices; byte address is four times the index
	localparam logic [7:0] IDX_DATA = 8'h86;
	localparam logic [7:0] IDX_STAT = 8'hAA;
	localparam logic [7:0] IDX_CTRL = 8'hD5;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	// Status bit positions
	localparam int ST_DONE = 7;
	localparam int ST_WRITE_COLLISION_FLAG = 6;
	localparam int ST_LDWIN = 5;
	localparam int ST_SLAVE_OUT_DISABLE = 1;
	localparam int ST_ENH = 0;
	localparam logic ST_SLAVE_OUT_DISABLE_RST = 1'b0;
	localparam logic ST_ENH_RST = 1'b0;
	// Half SCK periods minus one, in core clocks
	localparam logic [4:0] DIV_HALF_M1_F4 = 5'h01;
	localparam logic [4:0] DIV_HALF_M1_F8 = 5'h03;
	localparam logic [4:0] DIV_HALF_M1_F32 = 5'h0F;
	localparam logic [4:0] DIV_HALF_M1_F64 = 5'h1F;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [2:0] LOAD_WIN_END = 3'h4;
	localparam logic [3:0] LAST_EDGE = 4'hF;

	typedef struct packed {
		logic irq_en;
		logic spi_on;
		logic bit_order;
		logic master;
		logic clock_polarity;
		logic clock_phase;
		logic [1:0] rate;
	} sms_ctrl_t;

	typedef struct packed {
		logic sck;
		logic sck_oe;
		logic mosi;
		logic mosi_oe;
		logic miso;
		logic miso_oe;
	} sms_pins_t;
endpackage

// *** verilog/sms_clkdiv.sv ***
// Master SCK half-period tick divider
`timescale 1ns/10ps
module sms_clkdiv
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic run,
	input wire logic [1:0] rate,
	output logic tick
);
	logic [4:0] cnt_q;
	logic [4:0] cnt_d;
	logic [4:0] half_m1;
	logic at_end;

	assign half_m1 = (rate == 2'h0) ? sms_pkg::DIV_HALF_M1_F4 :
		(rate == 2'h1) ? sms_pkg::DIV_HALF_M1_F8 :
		(rate == 2'h2) ? sms_pkg::DIV_HALF_M1_F32 : sms_pkg::DIV_HALF_M1_F64;
	assign at_end = (cnt_q == half_m1);
	assign cnt_d = (!run || at_end) ? 5'h00 : cnt_q + 5'h01;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_q <= 5'h00;
			tick <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			tick <= run && at_end;
		end
	end
endmodule // sms_clkdiv

// *** verification/sms_slave_model.sv ***
// Behavioural SPI slave on the far side of the master link
`timescale 1ns/10ps
module sms_slave_model
(
	input wire logic sck,
	input wire logic mosi,
	input wire logic clock_polarity,
	input wire logic clock_phase,
	input wire logic load,
	input wire logic [7:0] tx_byte,
	output logic miso,
	output logic [7:0] rx_byte
);
	logic [7:0] out_q;
	initial
	begin
		out_q = 8'h00;
		rx_byte = 8'h00;
		miso = 1'b0;
	end
	// First bit ready before the first edge
	always @(posedge load)
	begin
		out_q = tx_byte;
		miso = tx_byte[7];
	end
	// Sample on the phase-selected edge, shift on the other
	always @(sck)
	begin
		if ((sck !== clock_polarity) ^ clock_phase)
			rx_byte = {rx_byte[6:0], mosi};
		else if (clock_phase)
		begin
			miso = out_q[7];
			out_q = out_q << 1;
		end
		else
		begin
			out_q = out_q << 1;
			miso = out_q[7];
		end
	end
endmodule // sms_slave_model

// *** verification/sms_spi_tb.sv ***
// Self-checking bench for the SPI master/slave unit
`timescale 1ns/10ps
module sms_spi_tb;
	logic core_clk, resetn, warm_reset, serial_irq_enable, ss_n_i, load, clock_polarity_b, clock_phase_b, sck_prev;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, spi_irq, miso_w;
	logic [sms_pkg::ADR_W-1:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [7:0] rd, tx, rx_m, keep, rx_s;
	logic sck_b, mosi_b;
	logic [1:0] mode;
	logic [7:0] half_tab [4] = '{8'h02, 8'h04, 8'h10, 8'h20};
	sms_pkg::sms_pins_t pins_o;
	int err_count, comparisons, cyc_n, half_n, last_half;
	sms_spi i_sms_spi (.core_clk(core_clk), .resetn(resetn), .warm_reset(warm_reset),
		.serial_irq_enable(serial_irq_enable), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.spi_irq(spi_irq), .sck_i(sck_b), .mosi_i(mosi_b), .miso_i(miso_w), .ss_n_i(ss_n_i), .pins_o(pins_o));
	// Miso is an input of the unit in master mode
	sms_slave_model i_sms_slave_model (.sck(pins_o.sck), .mosi(pins_o.mosi), .clock_polarity(clock_polarity_b), .clock_phase(clock_phase_b),
		.load(load), .tx_byte(tx), .miso(miso_w), .rx_byte(rx_m));
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// Cycle ceiling and SCK half-period meter
	always @(posedge core_clk)
	begin
		cyc_n++;
		half_n++;
		if (pins_o.sck !== sck_prev)
		begin
			last_half = half_n;
			half_n = 0;
		end
		sck_prev = pins_o.sck;
		if (cyc_n == 60000)
		begin
			err_count++;
			close_out();
		end
	end
	task close_out;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp)
		begin
			$display("BAD %s expected %h seen %h", nm, exp, got);
			err_count++;
		end
	endtask
	task wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {idx, 2'h0};
		wb_dat_i <= {24'h000000, d};
		do @(posedge core_clk); while (wb_ack_o !== 1'b1 && cyc_n < 60000);
		rd = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task wait_st(input int bit_n, input logic val);
		int k;
		k = 0;
		rd = {8{~val}};
		while (rd[bit_n] !== val && k < 400)
		begin
			wb(1'b0, sms_pkg::IDX_STAT, 8'h00);
			k++;
		end
	endtask
	task prime(input logic [7:0] b);
		tx <= b;
		load <= 1'b1;
		@(posedge core_clk);
		load <= 1'b0;
	endtask
	// Outside master, mode 0: mosi set with clock low, miso taken before rise
	task sl_xfer(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
		begin
			mosi_b <= b[i];
			sck_b <= 1'b0;
			repeat (2) @(posedge core_clk);
			rx_s = {rx_s[6:0], pins_o.miso};
			sck_b <= 1'b1;
			repeat (2) @(posedge core_clk);
		end
	endtask
	function automatic logic [7:0] rev(input logic [7:0] v);
		for (int i = 0; i < 8; i++)
			rev[i] = v[7 - i];
	endfunction
	initial
	begin
		{resetn, warm_reset, serial_irq_enable, load, clock_polarity_b, clock_phase_b, wb_cyc_i, wb_stb_i, wb_we_i} = 9'h000;
		{ss_n_i, sck_prev} = 2'h2;
		{wb_adr_i, wb_dat_i, tx} = 50'h0;
		{sck_b, mosi_b, rx_s} = 10'h0;
		{err_count, comparisons, cyc_n, half_n, last_half} = 160'h0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		wb(1'b0, sms_pkg::IDX_STAT, 8'h00);
		chk("status", 8'h20, rd);
		wb(1'b0, sms_pkg::IDX_CTRL, 8'h00);
		chk("control", 8'h00, rd);
		wb(1'b1, 8'h10, 8'h55);
		wb(1'b0, 8'h10, 8'h00);
		chk("unmapped", 8'h00, rd);
		for (int m = 0; m < 4; m++)
		begin
			mode = m[1:0];
			wb(1'b1, sms_pkg::IDX_CTRL, {6'h24, mode} | {4'h0, mode, 2'h0});
			wb(1'b1, sms_pkg::IDX_CTRL, {6'h34, mode} | {4'h0, mode, 2'h0});
			clock_polarity_b <= mode[1];
			clock_phase_b <= mode[0];
			serial_irq_enable <= mode[0];
			prime(8'h5A ^ {6'h00, mode});
			wb(1'b1, sms_pkg::IDX_DATA, 8'hA0 + {6'h00, mode});
			wait_st(7, 1'b1);
			chk("irq", {7'h00, mode[0]}, {7'h00, spi_irq});
			chk("half", half_tab[mode], last_half[7:0]);
			wb(1'b0, sms_pkg::IDX_DATA, 8'h00);
			chk("rx", tx, rd);
			chk("model", 8'hA0 + {6'h00, mode}, rx_m);
			wb(1'b0, sms_pkg::IDX_STAT, 8'h00);
			chk("clear", 8'h20, rd);
		end
		wb(1'b1, sms_pkg::IDX_CTRL, 8'h50);
		{clock_polarity_b, clock_phase_b} <= 2'h0;
		prime(8'h0F);
		wb(1'b1, sms_pkg::IDX_DATA, 8'h3C);
		wb(1'b1, sms_pkg::IDX_DATA, 8'hC3);
		wb(1'b0, sms_pkg::IDX_STAT, 8'h00);
		chk("write_collision_flag", 8'h40, rd & 8'h40);
		wait_st(7, 1'b1);
		chk("kept", 8'h3C, rx_m);
		wb(1'b0, sms_pkg::IDX_DATA, 8'h00);
		wb(1'b0, sms_pkg::IDX_STAT, 8'h00);
		chk("wclr", 8'h20, rd);
		wb(1'b1, sms_pkg::IDX_CTRL, 8'h70);
		prime(8'h2D);
		wb(1'b1, sms_pkg::IDX_DATA, 8'h1E);
		wait_st(7, 1'b1);
		wb(1'b0, sms_pkg::IDX_DATA, 8'h00);
		chk("lsb", rev(8'h2D), rd);
		chk("lsbm", rev(8'h1E), rx_m);
		wb(1'b1, sms_pkg::IDX_CTRL, 8'h50);
		wb(1'b1, sms_pkg::IDX_STAT, 8'h01);
		wb(1'b1, sms_pkg::IDX_DATA, 8'h11);
		wb(1'b0, sms_pkg::IDX_STAT, 8'h00);
		chk("ldwin", 8'h21, rd & 8'h61);
		wb(1'b1, sms_pkg::IDX_DATA, 8'h22);
		wb(1'b1, sms_pkg::IDX_DATA, 8'h33);
		wb(1'b0, sms_pkg::IDX_STAT, 8'h00);
		chk("full", 8'h40, rd & 8'h40);
		wait_st(6, 1'b0);
		chk("unload", 8'h80, rd & 8'hC0);
		wb(1'b0, sms_pkg::IDX_DATA, 8'h00);
		wait_st(7, 1'b1);
		chk("replace", 8'h33, rx_m);
		wb(1'b0, sms_pkg::IDX_DATA, 8'h00);
		keep = rd;
		warm_reset <= 1'b1;
		@(posedge core_clk);
		warm_reset <= 1'b0;
		wb(1'b0, sms_pkg::IDX_DATA, 8'h00);
		chk("warm", keep, rd);
		wb(1'b1, sms_pkg::IDX_CTRL, 8'h40);
		ss_n_i <= 1'b0;
		wb(1'b1, sms_pkg::IDX_DATA, 8'h96);
		sl_xfer(8'h3C);
		chk("sout", 8'h96, rx_s);
		wb(1'b0, sms_pkg::IDX_STAT, 8'h00);
		wb(1'b0, sms_pkg::IDX_DATA, 8'h00);
		chk("sin", 8'h3C, rd);
		sl_xfer(8'h00);
		chk("echo", 8'h3C, rx_s);
		wb(1'b1, sms_pkg::IDX_STAT, 8'h02);
		repeat (2) @(posedge core_clk);
		chk("slave_out_disable", 8'h00, {7'h00, pins_o.miso_oe});
		wb(1'b1, sms_pkg::IDX_STAT, 8'h00);
		repeat (2) @(posedge core_clk);
		chk("drive", 8'h01, {7'h00, pins_o.miso_oe});
		close_out();
	end
endmodule // sms_spi_tb
